// *** sysconfig_consts.svh ***
// Notes on behaviour
// - start field N selects N-kilobyte boundary
// - zero field: program space at RAM base
// - all-ones field: 255-kilobyte boundary start
// - debug enable bit gates the debug port
// - debug enable resets from fuse bit
// - unimplemented bits read back as zero
// - id: 4-bit revision over 28-bit part
// - id values fixed per variant, not reset
// - write-only key register, resets zero
// - clear, set, invert aliases at 4,8,C
// - bit2 converter ref, bit1 comparator ref
`ifndef SYSCONFIG_CONSTS_SVH
`define SYSCONFIG_CONSTS_SVH
// byte offsets of the bank, chosen locally
`define OFS_CONFIG 8'h00
`define OFS_IDREG 8'h10
`define OFS_KEY 8'h20
`define OFS_BG 8'h30
`define OFS_BG_CLR 8'h34
`define OFS_BG_SET 8'h38
`define OFS_BG_INV 8'h3C
// field positions
`define EXEC_HI 23
`define EXEC_LO 16
`define DBG_BIT 3
`define BG_MASK 32'h0000_0006
`define CFG_RSV_ONES 32'h0000_0003
// ram program space base and granule shift
`define RAM_BASE 32'hA000_0000
`define KB_SHIFT 10
// unlock sequence words (values arbitrary)
`define KEY_FIRST 32'h1234_5678
`define KEY_SECOND 32'h8765_4321
// axi response codes
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// *** sysconfig_pkg.sv ***
package sysconfig_pkg;
  // unlock sequencer states
  typedef enum logic [2:0]
  {
    LK_LOCKED = 3'b001,
    LK_HALF = 3'b010,
    LK_OPEN = 3'b100
  } lock_state_e;
endpackage

// *** system_config_register_bank.sv ***
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "sysconfig_consts.svh"
module system_config_register_bank
  import sysconfig_pkg::*;
#(
  parameter logic [3:0] REVISION = 4'h1, // arbitrary value
  parameter logic [27:0] PART_ID = 28'h000_0ABC // arbitrary value
)
(
  input wire logic clock, // 10 MHz system clock
  input wire logic reset, // async, active high
  input wire logic debug_fuse_bit, // fuse copy of debug enable
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic hw_converter_set, // hardware sets converter ref
  input wire logic hw_converter_clr, // hardware clears converter ref
  input wire logic hw_comparator_set, // hardware sets comparator ref
  input wire logic hw_comparator_clr, // hardware clears comparator ref
  output logic debug_port_enable, // debug port on
  output logic converter_ref_enable, // converter band gap on
  output logic comparator_ref_enable, // comparator band gap on
  output logic [31:0] ram_exec_start_addr, // program space start
  output logic system_unlocked // protected registers writable
);

  // held write channel state
  logic [7:0] aw_addr_reg; // latched write address
  logic aw_have_reg; // address captured
  logic [31:0] w_data_reg; // latched write data
  logic [3:0] w_strb_reg; // latched strobes
  logic w_have_reg; // data captured
  logic [7:0] ram_exec_start_sel_reg; // program space start field
  logic debug_port_enable_reg; // debug enable bit
  logic fuse_loaded_reg; // fuse sampled after release
  logic [31:0] bandgap_reg; // band gap control
  logic [31:0] unlock_key_word_reg; // last key word, never read
  lock_state_e lock_reg; // unlock sequencer
  logic do_write; // write commit this cycle
  logic [31:0] wmask; // byte lanes as bit mask
  logic [31:0] wbits; // strobed data
  logic [31:0] bg_next; // band gap next value
  logic [31:0] rd_value; // decoded read word
  logic rd_hit; // read address mapped
  logic wr_hit; // write address mapped

  // take each channel once, hold until the response is gone
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
  assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;

  // strobe expansion
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      assign wmask[gi*8 +: 8] = {8{w_strb_reg[gi]}};
    end
  endgenerate
  assign wbits = w_data_reg & wmask;

  // address and data capture, in either order
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      else if (do_write)
        aw_have_reg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      else if (do_write)
        w_have_reg <= 1'b0;
    end
  end

  // write address decode
  always_comb
  begin
    if (aw_addr_reg == `OFS_CONFIG || aw_addr_reg == `OFS_IDREG)
      wr_hit = 1'b1;
    else if (aw_addr_reg == `OFS_KEY || aw_addr_reg == `OFS_BG)
      wr_hit = 1'b1;
    else if (aw_addr_reg == `OFS_BG_CLR || aw_addr_reg == `OFS_BG_SET)
      wr_hit = 1'b1;
    else if (aw_addr_reg == `OFS_BG_INV)
      wr_hit = 1'b1;
    else
      wr_hit = 1'b0;
  end

  // write response, one cycle after both halves are in
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // config register: field and debug enable, fuse copied after reset
  // release since an async reset may only load constants
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      ram_exec_start_sel_reg <= 8'h00;
      debug_port_enable_reg <= 1'b0;
      fuse_loaded_reg <= 1'b0;
    end
    else if (!fuse_loaded_reg)
    begin
      fuse_loaded_reg <= 1'b1;
      debug_port_enable_reg <= debug_fuse_bit;
    end
    else if (do_write && aw_addr_reg == `OFS_CONFIG)
    begin
      // reserved and unimplemented bits are not stored
      if (w_strb_reg[2])
        ram_exec_start_sel_reg <= wbits[`EXEC_HI:`EXEC_LO];
      if (w_strb_reg[0])
        debug_port_enable_reg <= wbits[`DBG_BIT];
    end
  end

  // band gap aliases; bus write wins over hardware in same cycle
  always_comb
  begin
    bg_next = bandgap_reg;
    if (hw_converter_set)
      bg_next[2] = 1'b1;
    else if (hw_converter_clr)
      bg_next[2] = 1'b0;
    if (hw_comparator_set)
      bg_next[1] = 1'b1;
    else if (hw_comparator_clr)
      bg_next[1] = 1'b0;
    if (do_write)
    begin
      if (aw_addr_reg == `OFS_BG)
        bg_next = (bandgap_reg & ~wmask) | wbits;
      else if (aw_addr_reg == `OFS_BG_CLR)
        bg_next = bandgap_reg & ~wbits;
      else if (aw_addr_reg == `OFS_BG_SET)
        bg_next = bandgap_reg | wbits;
      else if (aw_addr_reg == `OFS_BG_INV)
        bg_next = bandgap_reg ^ wbits;
    end
    bg_next = bg_next & `BG_MASK;
  end

  // band gap register
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      bandgap_reg <= 32'h0000_0000;
    else
      bandgap_reg <= bg_next;
  end

  // key register and unlock sequencer; a wrong word relocks
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      unlock_key_word_reg <= 32'h0000_0000;
      lock_reg <= LK_LOCKED;
    end
    else if (do_write && aw_addr_reg == `OFS_KEY)
    begin
      unlock_key_word_reg <= wbits;
      case (lock_reg)
        LK_LOCKED:
          lock_reg <= (wbits == `KEY_FIRST) ? LK_HALF : LK_LOCKED;
        LK_HALF:
          lock_reg <= (wbits == `KEY_SECOND) ? LK_OPEN : LK_LOCKED;
        default:
          lock_reg <= LK_LOCKED;
      endcase
    end
  end

  // read decode; key reads zero, id is constant per variant
  always_comb
  begin
    rd_hit = 1'b1;
    rd_value = 32'h0000_0000;
    if (s_axi_araddr == `OFS_CONFIG)
      rd_value = {8'h00, ram_exec_start_sel_reg, 12'h000,
        debug_port_enable_reg, 3'b000};
    else if (s_axi_araddr == `OFS_IDREG)
      rd_value = {REVISION, PART_ID};
    else if (s_axi_araddr == `OFS_KEY)
      rd_value = 32'h0000_0000;
    else if (s_axi_araddr == `OFS_BG)
      rd_value = bandgap_reg;
    else if (s_axi_araddr == `OFS_BG_CLR || s_axi_araddr == `OFS_BG_SET)
      rd_value = bandgap_reg;
    else if (s_axi_araddr == `OFS_BG_INV)
      rd_value = bandgap_reg;
    else
      rd_hit = 1'b0;
  end

  assign s_axi_arready = !s_axi_rvalid;

  // read response, one cycle after the address
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // decoded outputs
  assign debug_port_enable = debug_port_enable_reg;
  assign converter_ref_enable = bandgap_reg[2];
  assign comparator_ref_enable = bandgap_reg[1];
  assign system_unlocked = (lock_reg == LK_OPEN);
  // start = base + N kilobytes, covers zero and all-ones cases
  assign ram_exec_start_addr = `RAM_BASE
    | ({24'h00_0000, ram_exec_start_sel_reg} << `KB_SHIFT);

  // the address is checked against a product, not the shift above
  a_exec_addr_map: assert property (
    @(posedge clock) disable iff (reset)
    ram_exec_start_addr == `RAM_BASE + 32'(ram_exec_start_sel_reg) * 1024)
    else $error("exec start address wrong");
  // zero field gives all of data ram as program space
  a_exec_zero_base: assert property (
    @(posedge clock) disable iff (reset)
    ram_exec_start_sel_reg == 8'h00 |-> ram_exec_start_addr == `RAM_BASE)
    else $error("zero field not at base");
  // all-ones field lands on the last kilobyte boundary
  a_exec_ones_top: assert property (
    @(posedge clock) disable iff (reset)
    ram_exec_start_sel_reg == 8'hFF |-> ram_exec_start_addr == 32'hA003_FC00)
    else $error("all ones field wrong");
  // the field takes a config write once the fuse copy is done
  a_exec_field_write: assert property (
    @(posedge clock) disable iff (reset)
    do_write && aw_addr_reg == `OFS_CONFIG && w_strb_reg[2] && fuse_loaded_reg
    |=> ram_exec_start_sel_reg == $past(w_data_reg[`EXEC_HI:`EXEC_LO]))
    else $error("exec field write lost");
  // first edge after release copies the fuse into the enable
  a_debug_fuse_load: assert property (
    @(posedge clock) disable iff (reset)
    !fuse_loaded_reg |=> debug_port_enable == $past(debug_fuse_bit))
    else $error("debug enable not from fuse");
  // a config write with lane 0 moves the debug enable
  a_debug_write_bit: assert property (
    @(posedge clock) disable iff (reset)
    do_write && aw_addr_reg == `OFS_CONFIG && w_strb_reg[0] && fuse_loaded_reg
    |=> debug_port_enable == $past(w_data_reg[`DBG_BIT]))
    else $error("debug enable write lost");
  // unimplemented config bits read back as zero
  a_cfg_zero_bits: assert property (
    @(posedge clock) disable iff (reset)
    s_axi_rvalid && $past(s_axi_araddr) == `OFS_CONFIG && $past(s_axi_arready)
    |-> (s_axi_rdata & 32'hFF00_FFF7) == 32'h0000_0000)
    else $error("config unimplemented bits set");
  // id word is the variant's constants, whatever was written
  a_id_read_value: assert property (
    @(posedge clock) disable iff (reset)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFS_IDREG
    |=> s_axi_rdata == {REVISION, PART_ID})
    else $error("id read wrong");
  // the key never reads back
  a_key_reads_zero: assert property (
    @(posedge clock) disable iff (reset)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFS_KEY
    |=> s_axi_rdata == 32'h0000_0000)
    else $error("key register readable");
  // the write-only key holds the last word written
  a_key_word_capture: assert property (
    @(posedge clock) disable iff (reset)
    do_write && aw_addr_reg == `OFS_KEY
    |=> unlock_key_word_reg == $past(wbits))
    else $error("key word not captured");
  // set alias: bus write beats a hardware clear in the same cycle
  a_bg_set_alias: assert property (
    @(posedge clock) disable iff (reset)
    do_write && aw_addr_reg == `OFS_BG_SET && w_strb_reg[0] && w_data_reg[2]
    |=> converter_ref_enable)
    else $error("set alias failed");
  // clear alias drops only the bits written as one
  a_bg_clr_alias: assert property (
    @(posedge clock) disable iff (reset)
    do_write && aw_addr_reg == `OFS_BG_CLR && w_strb_reg[0] && w_data_reg[2]
    && !w_data_reg[1]
    |=> !converter_ref_enable
      && comparator_ref_enable == $past(comparator_ref_enable))
    else $error("clear alias failed");
  // hardware set reaches the enable when the bus is quiet
  a_bg_hw_set: assert property (
    @(posedge clock) disable iff (reset)
    hw_converter_set && !do_write |=> converter_ref_enable)
    else $error("hardware set lost");
  // nothing outside the two enables is ever stored
  a_bg_only_two: assert property (
    @(posedge clock) disable iff (reset)
    (bandgap_reg & 32'hFFFF_FFF9) == 32'h0000_0000)
    else $error("band gap stray bits");
  // any key write while open locks again
  a_key_relock: assert property (
    @(posedge clock) disable iff (reset)
    do_write && aw_addr_reg == `OFS_KEY && system_unlocked
    |=> !system_unlocked)
    else $error("key write did not relock");

endmodule

// *** tb.sv ***
`timescale 1ns/1ps
`include "sysconfig_consts.svh"
module tb;
  logic clock = 0; // 100 ns system clock
  logic reset = 1; // async, active high
  logic fuse = 1; // fuse copy of debug enable
  logic [7:0] awaddr = 0, araddr = 0; // bus addresses
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rnd = 32'h768f_7ab1; // write data, random state
  logic awready, wready, bvalid, arready, rvalid; // slave handshakes
  logic [1:0] bresp, rresp; // response codes
  logic [31:0] rdata, exec_addr; // read data, program space start
  logic hcv_set = 0, hcv_clr = 0, hcp_set = 0, hcp_clr = 0; // hw pokes
  logic dbg_en, cv_en, cp_en, unlocked; // level outputs
  logic [3:0] wstrb = 4'hF; // write byte lanes
  logic [1:0] exp_b[$]; // expected write responses
  logic [33:0] exp_r[$]; // expected {rresp, rdata}
  int bad_count = 0, checks = 0; // mismatch and compare counters
  logic [7:0] fld; // exec start field under test
  logic [33:0] er; // popped read expectation
  system_config_register_bank i_dut (.clock(clock), .reset(reset),
    .debug_fuse_bit(fuse), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .hw_converter_set(hcv_set), .hw_converter_clr(hcv_clr),
    .hw_comparator_set(hcp_set), .hw_comparator_clr(hcp_clr),
    .debug_port_enable(dbg_en), .converter_ref_enable(cv_en),
    .comparator_ref_enable(cp_en), .ram_exec_start_addr(exec_addr),
    .system_unlocked(unlocked));
  // free-running clock
  always #50 clock = ~clock;
  // galois-free shift register step for stimulus values
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // verdict and end of run, the single exit point
  task report_and_stop;
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one comparison by case inequality, an unknown matches only an unknown
  task check(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // one edge with a bound, so a stalled slave cannot hang the run
  task tick(inout int n);
    @(posedge clock);
    n++;
    if (n > 100)
    begin
      bad_count++;
      report_and_stop;
    end
  endtask
  // axi4-lite write; address and data offered together, released when taken
  task axi_write(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] eb);
    int n;
    logic aw_ok, w_ok;
    n = 0;
    aw_ok = 0;
    w_ok = 0;
    exp_b.push_back(eb);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw_ok && w_ok))
    begin
      tick(n);
      if (awvalid && awready)
      begin
        aw_ok = 1;
        awvalid <= 0;
      end
      if (wvalid && wready)
      begin
        w_ok = 1;
        wvalid <= 0;
      end
    end
    do tick(n); while (!bvalid);
    bready <= 0;
    // one idle edge so the next call never re-raises bready at once
    @(posedge clock);
  endtask
  // axi4-lite read; rready held until rvalid is seen
  task axi_read(input logic [7:0] a, input logic [33:0] e);
    int n;
    n = 0;
    exp_r.push_back(e);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do tick(n); while (!arready);
    arvalid <= 0;
    while (!rvalid)
      tick(n);
    if (n == 0)
      tick(n);
    rready <= 0;
    // one idle edge so the next call never re-raises rready at once
    @(posedge clock);
  endtask
  // watcher: every completed response is matched to the oldest note
  always @(posedge clock)
  begin
    if (bvalid && bready)
    begin
      // a response with no note expects unknown, so it always mismatches
      er[1:0] = (exp_b.size() > 0) ? exp_b.pop_front() : 2'bxx;
      check({32'h0, bresp}, {32'h0, er[1:0]});
    end
    if (rvalid && rready)
    begin
      er = (exp_r.size() > 0) ? exp_r.pop_front() : 34'bx;
      check({rresp, rdata}, er);
    end
  end
  // main sequence
  initial
  begin
    repeat (4) @(posedge clock);
    reset <= 0;
    repeat (3) @(posedge clock);
    check(dbg_en, 1'b1);
    check(exec_addr, `RAM_BASE);
    axi_read(`OFS_CONFIG, {2'b00, 32'h0000_0008});
    // exec field corner values, then random ones; junk in unused bits
    for (int i = 0; i < 6; i++)
    begin
      rnd = lfsr(rnd);
      fld = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'hFF : rnd[7:0];
      axi_write(`OFS_CONFIG,
        {8'hF4, fld, 12'hFFF, i[0], 3'b111}, 2'b00);
      check(exec_addr, `RAM_BASE + {24'h0, fld} * 1024);
      check(dbg_en, i[0]);
      axi_read(`OFS_CONFIG,
        {2'b00, 8'h00, fld, 12'h000, i[0], 3'b000});
    end
    // lane 2 only: the field moves, the debug enable keeps its value
    wstrb <= 4'h4;
    axi_write(`OFS_CONFIG,
      {8'h00, 8'h5A, 12'h000, 1'b0, 3'b011}, 2'b00);
    wstrb <= 4'hF;
    check(exec_addr, `RAM_BASE + 32'h0001_6800);
    check(dbg_en, 1'b1);
    axi_read(`OFS_CONFIG, {2'b00, 32'h005A_0008});
    axi_write(`OFS_IDREG, rnd, 2'b00);
    axi_read(`OFS_IDREG, {2'b00, 4'h1, 28'h000_0ABC});
    // unlock sequence, then relock by a wrong key
    axi_write(`OFS_KEY, `KEY_FIRST, 2'b00);
    axi_write(`OFS_KEY, `KEY_SECOND, 2'b00);
    check(unlocked, 1'b1);
    axi_read(`OFS_KEY, {2'b00, 32'h0000_0000});
    axi_write(`OFS_KEY, rnd, 2'b00);
    check(unlocked, 1'b0);
    // band gap plain write, then each alias touching only ones
    axi_write(`OFS_BG, 32'hFFFF_FFFF, 2'b00);
    axi_read(`OFS_BG, {2'b00, 32'h0000_0006});
    axi_write(`OFS_BG_CLR, 32'h0000_0004, 2'b00);
    check({cv_en, cp_en}, 2'b01);
    axi_write(`OFS_BG_SET, 32'h0000_0004, 2'b00);
    axi_write(`OFS_BG_INV, 32'h0000_0002, 2'b00);
    axi_read(`OFS_BG, {2'b00, 32'h0000_0004});
    // hardware set and clear of the reference enables
    hcv_clr <= 1;
    hcp_set <= 1;
    @(posedge clock);
    hcv_clr <= 0;
    hcp_set <= 0;
    @(posedge clock);
    check({cv_en, cp_en}, 2'b01);
    hcv_set <= 1;
    hcp_clr <= 1;
    @(posedge clock);
    hcv_set <= 0;
    hcp_clr <= 0;
    @(posedge clock);
    check({cv_en, cp_en}, 2'b10);
    // unmapped address on both channels
    axi_write(8'h40, rnd, 2'b10);
    axi_read(8'h40, {2'b10, 32'h0000_0000});
    // second reset with the fuse cleared: the enable must follow the fuse
    fuse <= 0;
    reset <= 1;
    repeat (2) @(posedge clock);
    reset <= 0;
    repeat (3) @(posedge clock);
    check(dbg_en, 1'b0);
    check({cv_en, cp_en, unlocked}, 3'b000);
    check(exec_addr, `RAM_BASE);
    axi_read(`OFS_CONFIG, {2'b00, 32'h0000_0000});
    repeat (3) @(posedge clock);
    check(exp_b.size() + exp_r.size(), 0);
    report_and_stop;
  end
endmodule
